// ---- core/rbd_pkg.sv ----
/*
  rbd_pkg: opcode fields, addressing modes, operations, byte and cycle
  counts and condition-code bit positions for the register/memory and
  relative-branch decoder. Assumes an 8-bit core with a 16-bit program counter.
*/
package rbd_pkg;
  // opcode high nibble: addressing mode
  localparam logic [3:0] NIB_REL = 4'h2;
  localparam logic [3:0] NIB_IMM = 4'hA;
  localparam logic [3:0] NIB_DIR = 4'hB;
  localparam logic [3:0] NIB_EXT = 4'hC;
  localparam logic [3:0] NIB_IX2 = 4'hD;
  localparam logic [3:0] NIB_IX1 = 4'hE;
  localparam logic [3:0] NIB_IX  = 4'hF;
  // opcode low nibble: operation
  localparam logic [3:0] LN_SUB = 4'h0;
  localparam logic [3:0] LN_CPA = 4'h1;
  localparam logic [3:0] LN_SWB = 4'h2;
  localparam logic [3:0] LN_CPX = 4'h3;
  localparam logic [3:0] LN_AND = 4'h4;
  localparam logic [3:0] LN_BIT = 4'h5;
  localparam logic [3:0] LN_LDA = 4'h6;
  localparam logic [3:0] LN_STA = 4'h7;
  localparam logic [3:0] LN_XOR = 4'h8;
  localparam logic [3:0] LN_ADC = 4'h9;
  localparam logic [3:0] LN_ORA = 4'hA;
  localparam logic [3:0] LN_ADD = 4'hB;
  localparam logic [3:0] LN_JPA = 4'hC;
  localparam logic [3:0] LN_JPS = 4'hD;
  localparam logic [3:0] LN_LDX = 4'hE;
  localparam logic [3:0] LN_STX = 4'hF;
  localparam logic [7:0] OPC_BRANCH_SUB = 8'hAD;
  // branch conditions, coded by the low nibble of a 2x opcode
  localparam logic [3:0] BR_ALWAYS = 4'h0, BR_NEVER = 4'h1, BR_HIGHER = 4'h2, BR_LOWER_SAME = 4'h3;
  localparam logic [3:0] BR_CARRY_CLEAR = 4'h4, BR_CARRY_SET = 4'h5, BR_NOT_EQUAL = 4'h6, BR_EQUAL = 4'h7;
  localparam logic [3:0] BR_HALF_CLEAR = 4'h8, BR_HALF_SET = 4'h9, BR_PLUS = 4'hA, BR_MINUS = 4'hB;
  localparam logic [3:0] BR_MASK_CLEAR = 4'hC, BR_MASK_SET = 4'hD, BR_IRQ_LOW = 4'hE, BR_IRQ_HIGH = 4'hF;
  // condition_codes bit positions
  localparam int CC_H = 4;
  localparam int CC_I = 3;
  localparam int CC_N = 2;
  localparam int CC_Z = 1;
  localparam int CC_C = 0;
  // bytes and cycles per mode
  localparam logic [1:0] LEN_IMM = 2'd2, LEN_DIR = 2'd2, LEN_EXT = 2'd3;
  localparam logic [1:0] LEN_IX = 2'd1, LEN_IX1 = 2'd2, LEN_IX2 = 2'd3, LEN_REL = 2'd2;
  localparam logic [3:0] CYC_IMM = 4'h2, CYC_DIR = 4'h3, CYC_EXT = 4'h4;
  localparam logic [3:0] CYC_IX = 4'h3, CYC_IX1 = 4'h4, CYC_IX2 = 4'h5;
  localparam logic [3:0] CYC_REL = 4'h3, CYC_BSUB = 4'h6, CYC_UNSUP = 4'h2;
  localparam logic [3:0] CYC_STORE_ADD = 4'h1, CYC_JUMP_SUB = 4'h1, CYC_JPS_ADD = 4'h2;
  localparam logic [3:0] CNT_LAST = 4'h1;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic IRQ_IDLE = 1'b1;

  typedef enum logic [4:0] {
    OP_NONE, OP_SUB, OP_COMPARE_ACCUMULATOR, OP_SUBTRACT_WITH_BORROW, OP_CPX, OP_AND, OP_BIT_TEST,
    OP_LDA, OP_STA, OP_EXCLUSIVE_OR_ACC, OP_ADD_CARRY, OP_ORA, OP_ADD, OP_JUMP_ALWAYS,
    OP_JUMP_SUBROUTINE, OP_LDX, OP_STX, OP_BRANCH, OP_BRANCH_SUBROUTINE
  } rbd_op_type;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1, MODE_IX2, MODE_REL
  } rbd_mode_type;

  typedef enum logic {ST_IDLE, ST_EXEC} rbd_state_type;
endpackage

// ---- core/rbd_opdecode.sv ----
/*
  rbd_opdecode: combinational map of one opcode to operation, addressing
  mode, instruction length and cycle count. Assumes rbd_pkg is compiled first.
*/
`timescale 1ns/1ps
module rbd_opdecode (
  input  wire logic [7:0]           opcode,
  output rbd_pkg::rbd_op_type       op,
  output rbd_pkg::rbd_mode_type     mode,
  output logic [1:0]                len,
  output logic [3:0]                cycles,
  output logic                      legal
);
  import rbd_pkg::*;

  // mode from high nibble, operation from low nibble
  always_comb begin
    op = OP_NONE;
    mode = MODE_NONE;
    len = LEN_IMM;
    cycles = CYC_UNSUP;
    legal = 1'b1;
    case (opcode[7:4])
      NIB_IMM: begin mode = MODE_IMM; len = LEN_IMM; cycles = CYC_IMM; end
      NIB_DIR: begin mode = MODE_DIR; len = LEN_DIR; cycles = CYC_DIR; end
      NIB_EXT: begin mode = MODE_EXT; len = LEN_EXT; cycles = CYC_EXT; end
      NIB_IX:  begin mode = MODE_IX;  len = LEN_IX;  cycles = CYC_IX;  end
      NIB_IX1: begin mode = MODE_IX1; len = LEN_IX1; cycles = CYC_IX1; end
      NIB_IX2: begin mode = MODE_IX2; len = LEN_IX2; cycles = CYC_IX2; end
      NIB_REL: begin mode = MODE_REL; len = LEN_REL; cycles = CYC_REL; end
      default: legal = 1'b0;
    endcase
    if (mode == MODE_REL) begin
      op = OP_BRANCH;
    end else if (opcode == OPC_BRANCH_SUB) begin
      op = OP_BRANCH_SUBROUTINE;
      mode = MODE_REL;
      len = LEN_REL;
      cycles = CYC_BSUB;
    end else if (legal) begin
      case (opcode[3:0])
        LN_SUB: op = OP_SUB;
        LN_CPA: op = OP_COMPARE_ACCUMULATOR;
        LN_SWB: op = OP_SUBTRACT_WITH_BORROW;
        LN_CPX: op = OP_CPX;
        LN_AND: op = OP_AND;
        LN_BIT: op = OP_BIT_TEST;
        LN_LDA: op = OP_LDA;
        LN_STA: op = OP_STA;
        LN_XOR: op = OP_EXCLUSIVE_OR_ACC;
        LN_ADC: op = OP_ADD_CARRY;
        LN_ORA: op = OP_ORA;
        LN_ADD: op = OP_ADD;
        LN_JPA: op = OP_JUMP_ALWAYS;
        LN_JPS: op = OP_JUMP_SUBROUTINE;
        LN_LDX: op = OP_LDX;
        default: op = OP_STX;
      endcase
      // stores and jumps have no immediate form
      if (mode == MODE_IMM && (op == OP_STA || op == OP_STX || op == OP_JUMP_ALWAYS || op == OP_JUMP_SUBROUTINE))
        legal = 1'b0;
      if (op == OP_STA || op == OP_STX)
        cycles = cycles + CYC_STORE_ADD;
      if (op == OP_JUMP_ALWAYS)
        cycles = cycles - CYC_JUMP_SUB;
      if (op == OP_JUMP_SUBROUTINE)
        cycles = cycles + CYC_JPS_ADD;
    end
    if (!legal) begin
      op = OP_NONE;
      mode = MODE_NONE;
      cycles = CYC_UNSUP;
    end
  end
endmodule // rbd_opdecode

// ---- core/rbd_branch_eval.sv ----
/*
  rbd_branch_eval: condition test and target address of a relative branch.
  Assumes condition codes and the interrupt pin level are already stable.
*/
`timescale 1ns/1ps
module rbd_branch_eval (
  input  wire logic [3:0]  cond,
  input  wire logic        force_take,
  input  wire logic [4:0]  condition_codes,
  input  wire logic        irq_level,
  input  wire logic [15:0] seq_pc,
  input  wire logic [7:0]  offset,
  output logic             taken,
  output logic [15:0]      target
);
  import rbd_pkg::*;

  // condition test for one 2x opcode low nibble
  function automatic logic cond_met(input logic [3:0] c, input logic [4:0] f, input logic irq);
    case (c)
      BR_ALWAYS:      cond_met = 1'b1;
      BR_NEVER:       cond_met = 1'b0;
      BR_HIGHER:      cond_met = !(f[CC_C] | f[CC_Z]);
      BR_LOWER_SAME:  cond_met = f[CC_C] | f[CC_Z];
      BR_CARRY_CLEAR: cond_met = !f[CC_C];
      BR_CARRY_SET:   cond_met = f[CC_C];
      BR_NOT_EQUAL:   cond_met = !f[CC_Z];
      BR_EQUAL:       cond_met = f[CC_Z];
      BR_HALF_CLEAR:  cond_met = !f[CC_H];
      BR_HALF_SET:    cond_met = f[CC_H];
      BR_PLUS:        cond_met = !f[CC_N];
      BR_MINUS:       cond_met = f[CC_N];
      BR_MASK_CLEAR:  cond_met = !f[CC_I];
      BR_MASK_SET:    cond_met = f[CC_I];
      BR_IRQ_LOW:     cond_met = !irq;
      default:        cond_met = irq;
    endcase
  endfunction

  // taken branches add the signed offset to the following address
  always_comb begin
    taken = force_take | cond_met(cond, condition_codes, irq_level);
    target = seq_pc + {{8{offset[7]}}, offset};
  end
endmodule // rbd_branch_eval

// ---- core/rbd_decoder.sv ----
/*
  rbd_decoder: decodes and sequences register/memory and relative-branch
  instructions of an 8-bit core. Computes operation, mode, length, cycle
  count, effective address, next program counter, accumulator result and
  condition codes, and holds off the external interrupt while masked.
  Assumes the core presents the opcode, both following bytes, the operand
  value and its registers with start while busy is low.
*/
`timescale 1ns/1ps
module rbd_decoder (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          start,
  input  wire logic [7:0]    opcode,
  input  wire logic [7:0]    byte1,
  input  wire logic [7:0]    byte2,
  input  wire logic [15:0]   instr_pc,
  input  wire logic [7:0]    mem_data,
  input  wire logic [7:0]    acc_in,
  input  wire logic [7:0]    idx_in,
  input  wire logic [4:0]    ccr_in,
  input  wire logic          irq_pin,
  output logic               busy,
  output logic               done,
  output logic               irq_take,
  output rbd_pkg::rbd_op_type   op_out,
  output rbd_pkg::rbd_mode_type mode_out,
  output logic [1:0]         len_out,
  output logic [3:0]         cycles_out,
  output logic               illegal,
  output logic               branch_taken,
  output logic [15:0]        next_pc,
  output logic [15:0]        eff_addr,
  output logic               push_return,
  output logic [15:0]        return_addr,
  output logic [7:0]         result,
  output logic               acc_we,
  output logic               idx_we,
  output logic               mem_we,
  output logic [4:0]         ccr_out
);
  import rbd_pkg::*;

  rbd_op_type    dec_op;
  rbd_mode_type  dec_mode;
  logic [1:0]    dec_len;
  logic [3:0]    dec_cyc;
  logic          dec_legal;
  logic          br_taken;
  logic [15:0]   br_target;
  logic [15:0]   seq_pc;
  logic          irq_s1_ff, irq_s2_ff, irq_s3_ff, irq_lvl_ff, irq_pend_ff;
  logic          nxt_irq_lvl, nxt_irq_pend;
  rbd_state_type state_ff, nxt_state;
  logic [3:0]    cnt_ff, nxt_cnt;
  rbd_op_type    op_ff, nxt_op;
  rbd_mode_type  mode_ff, nxt_mode;
  logic [1:0]    len_ff, nxt_len;
  logic [3:0]    cyc_ff, nxt_cyc;
  logic          ill_ff, nxt_ill, taken_ff, nxt_taken, push_ff, nxt_push;
  logic [15:0]   pc_ff, nxt_pc, ea_ff, nxt_ea, ret_ff, nxt_ret;
  logic [7:0]    res_ff, nxt_res;
  logic          awe_ff, nxt_awe, xwe_ff, nxt_xwe, mwe_ff, nxt_mwe;
  logic [4:0]    ccr_ff, nxt_ccr;
  logic [15:0]   ea;
  logic [7:0]    opnd, alu;
  logic [8:0]    wide;
  logic          take;

  rbd_opdecode u_dec (
    .opcode (opcode),
    .op     (dec_op),
    .mode   (dec_mode),
    .len    (dec_len),
    .cycles (dec_cyc),
    .legal  (dec_legal)
  );

  // sequential address follows the whole instruction
  assign seq_pc = instr_pc + {14'h0000, dec_len};

  rbd_branch_eval u_br (
    .cond       (opcode[3:0]),
    .force_take (dec_op == OP_BRANCH_SUBROUTINE),
    .condition_codes        (ccr_in),
    .irq_level  (irq_lvl_ff),
    .seq_pc     (seq_pc),
    .offset     (byte1),
    .taken      (br_taken),
    .target     (br_target)
  );

  // interrupt pin: level counts once the last two stages agree; falling edge latches
  always_comb begin
    nxt_irq_lvl = (irq_s2_ff == irq_s3_ff) ? irq_s3_ff : irq_lvl_ff;
    nxt_irq_pend = (irq_lvl_ff & ~nxt_irq_lvl) | (irq_pend_ff & ~irq_take);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_s1_ff <= IRQ_IDLE;
      irq_s2_ff <= IRQ_IDLE;
      irq_s3_ff <= IRQ_IDLE;
      irq_lvl_ff <= IRQ_IDLE;
      irq_pend_ff <= 1'b0;
    end else begin
      irq_s1_ff <= irq_pin;
      irq_s2_ff <= irq_s1_ff;
      irq_s3_ff <= irq_s2_ff;
      irq_lvl_ff <= nxt_irq_lvl;
      irq_pend_ff <= nxt_irq_pend;
    end
  end

  // handshakes
  assign take = start && (state_ff == ST_IDLE);
  assign busy = (state_ff != ST_IDLE);
  assign done = (state_ff == ST_EXEC) && (cnt_ff == CNT_LAST);
  assign irq_take = irq_pend_ff && !ccr_in[CC_I] && (state_ff == ST_IDLE) && !start;

  // effective address per mode
  always_comb begin
    case (dec_mode)
      MODE_DIR: ea = {PAGE_ZERO, byte1};
      MODE_EXT: ea = {byte1, byte2};
      MODE_IX:  ea = {PAGE_ZERO, idx_in};
      MODE_IX1: ea = {PAGE_ZERO, byte1} + {PAGE_ZERO, idx_in};
      MODE_IX2: ea = {byte1, byte2} + {PAGE_ZERO, idx_in};
      default:  ea = seq_pc;
    endcase
  end

  // accumulator and index arithmetic with condition codes
  always_comb begin
    opnd = (dec_mode == MODE_IMM) ? byte1 : mem_data;
    wide = {1'b0, acc_in};
    alu = acc_in;
    nxt_ccr = ccr_in;
    nxt_awe = 1'b0;
    nxt_xwe = 1'b0;
    nxt_mwe = 1'b0;
    case (dec_op)
      OP_ADD, OP_ADD_CARRY: begin
        wide = {1'b0, acc_in} + {1'b0, opnd} + {8'h00, (dec_op == OP_ADD_CARRY) & ccr_in[CC_C]};
        nxt_awe = 1'b1;
      end
      OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_COMPARE_ACCUMULATOR: begin
        wide = {1'b0, acc_in} - {1'b0, opnd} - {8'h00, (dec_op == OP_SUBTRACT_WITH_BORROW) & ccr_in[CC_C]};
        nxt_awe = (dec_op != OP_COMPARE_ACCUMULATOR);
      end
      OP_CPX: wide = {1'b0, idx_in} - {1'b0, opnd};
      OP_AND: begin alu = acc_in & opnd; nxt_awe = 1'b1; end
      OP_BIT_TEST: alu = acc_in & opnd;
      OP_EXCLUSIVE_OR_ACC: begin alu = acc_in ^ opnd; nxt_awe = 1'b1; end
      OP_ORA: begin alu = acc_in | opnd; nxt_awe = 1'b1; end
      OP_LDA: begin alu = opnd; nxt_awe = 1'b1; end
      OP_LDX: begin alu = opnd; nxt_xwe = 1'b1; end
      OP_STA: nxt_mwe = 1'b1;
      OP_STX: begin alu = idx_in; nxt_mwe = 1'b1; end
      default: alu = acc_in;  // jumps and branches leave data and flags alone
    endcase
    case (dec_op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_COMPARE_ACCUMULATOR, OP_CPX: begin
        alu = wide[7:0];
        nxt_ccr[CC_C] = wide[8];
      end
      default: alu = alu;
    endcase
    if (dec_op == OP_ADD || dec_op == OP_ADD_CARRY)
      nxt_ccr[CC_H] = (acc_in[3] & opnd[3]) | (opnd[3] & ~alu[3]) | (~alu[3] & acc_in[3]);
    if (dec_op inside {[OP_SUB:OP_STA], OP_EXCLUSIVE_OR_ACC, OP_ADD_CARRY, OP_ORA, OP_ADD, OP_LDX, OP_STX}) begin
      nxt_ccr[CC_N] = alu[7];
      nxt_ccr[CC_Z] = (alu == 8'h00);
    end
    nxt_res = alu;
  end

  // instruction sequencing and registered decode results
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    nxt_mode = mode_ff;
    nxt_len = len_ff;
    nxt_cyc = cyc_ff;
    nxt_ill = ill_ff;
    nxt_taken = taken_ff;
    nxt_push = push_ff;
    nxt_pc = pc_ff;
    nxt_ea = ea_ff;
    nxt_ret = ret_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_EXEC;
          nxt_cnt = dec_cyc - CNT_LAST;
          nxt_op = dec_op;
          nxt_mode = dec_mode;
          nxt_len = dec_len;
          nxt_cyc = dec_cyc;
          nxt_ill = !dec_legal;
          nxt_taken = 1'b0;
          nxt_push = 1'b0;
          nxt_ret = seq_pc;
          nxt_ea = ea;
          nxt_pc = seq_pc;
          if (dec_op == OP_BRANCH || dec_op == OP_BRANCH_SUBROUTINE) begin
            nxt_taken = br_taken;
            nxt_ea = br_target;
            nxt_pc = br_taken ? br_target : seq_pc;
            nxt_push = (dec_op == OP_BRANCH_SUBROUTINE);
          end else if (dec_op == OP_JUMP_ALWAYS || dec_op == OP_JUMP_SUBROUTINE) begin
            nxt_taken = 1'b1;
            nxt_pc = ea;
            nxt_push = (dec_op == OP_JUMP_SUBROUTINE);
          end
        end
      end
      ST_EXEC: begin
        nxt_cnt = cnt_ff - CNT_LAST;
        if (cnt_ff == CNT_LAST)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      op_ff <= OP_NONE;
      mode_ff <= MODE_NONE;
      len_ff <= 2'h0;
      cyc_ff <= 4'h0;
      ill_ff <= 1'b0;
      taken_ff <= 1'b0;
      push_ff <= 1'b0;
      pc_ff <= 16'h0000;
      ea_ff <= 16'h0000;
      ret_ff <= 16'h0000;
      res_ff <= 8'h00;
      awe_ff <= 1'b0;
      xwe_ff <= 1'b0;
      mwe_ff <= 1'b0;
      ccr_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      mode_ff <= nxt_mode;
      len_ff <= nxt_len;
      cyc_ff <= nxt_cyc;
      ill_ff <= nxt_ill;
      taken_ff <= nxt_taken;
      push_ff <= nxt_push;
      pc_ff <= nxt_pc;
      ea_ff <= nxt_ea;
      ret_ff <= nxt_ret;
      if (take) begin
        res_ff <= nxt_res;
        awe_ff <= nxt_awe;
        xwe_ff <= nxt_xwe;
        mwe_ff <= nxt_mwe;
        ccr_ff <= nxt_ccr;
      end
    end
  end

  // registered outputs hold from one take to the next
  assign op_out = op_ff;
  assign mode_out = mode_ff;
  assign len_out = len_ff;
  assign cycles_out = cyc_ff;
  assign illegal = ill_ff;
  assign branch_taken = taken_ff;
  assign next_pc = pc_ff;
  assign eff_addr = ea_ff;
  assign push_return = push_ff;
  assign return_addr = ret_ff;
  assign result = res_ff;
  assign acc_we = awe_ff;
  assign idx_we = xwe_ff;
  assign mem_we = mwe_ff;
  assign ccr_out = ccr_ff;
endmodule // rbd_decoder

// ---- sim/rbd_decoder_assertions.sv ----
/*
  rbd_decoder_assertions: concurrent checks on the decoder's top ports.
  Assumes a bind to rbd_decoder; sees only its ports.
*/
`timescale 1ns/1ps
module rbd_decoder_assertions (
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          start,
  input wire logic [7:0]    opcode,
  input wire logic [7:0]    byte1,
  input wire logic [15:0]   instr_pc,
  input wire logic [4:0]    ccr_in,
  input wire logic          busy,
  input wire logic          done,
  input rbd_pkg::rbd_op_type op_out,
  input wire logic [1:0]    len_out,
  input wire logic [3:0]    cycles_out,
  input wire logic          branch_taken,
  input wire logic [15:0]   next_pc,
  input wire logic          push_return,
  input wire logic [15:0]   return_addr,
  input wire logic          acc_we,
  input wire logic [4:0]    ccr_out
);
  import rbd_pkg::*;
  logic [3:0] cnt_ff;  // cycles since the take edge

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // count the cycles of the running instruction
  always_ff @(posedge clk) begin
    if (reset) cnt_ff <= 4'h0;
    else if (start && !busy) cnt_ff <= 4'h1;
    else if (busy) cnt_ff <= cnt_ff + 4'h1;
  end

  // a request is taken only while idle
  sequence s_take;
    start && !busy;
  endsequence
  sequence s_rel;
    s_take ##0 opcode[7:4] == NIB_REL;
  endsequence

  chk_busy_after_take: assert property (s_take |=> busy)
    else $error("busy not raised after take");
  chk_done_count: assert property (done |-> cnt_ff == cycles_out - 4'h1 ##1 !busy)
    else $error("done not in the last cycle of the instruction");
  chk_adc_imm: assert property (s_take ##0 opcode == 8'hA9 |=>
      op_out == OP_ADD_CARRY && len_out == 2'd2 && cycles_out == 4'h2)
    else $error("immediate add with carry decoded wrongly");
  chk_rel_size: assert property (s_rel |=> len_out == 2'd2 && cycles_out == 4'h3 ##1 done)
    else $error("relative branch length or timing wrong");
  chk_flags_only: assert property (s_take ##0 opcode[7:4] >= 4'hA &&
      (opcode[3:0] == LN_CPA || opcode[3:0] == LN_BIT) |=> !acc_we)
    else $error("compare wrote the accumulator");
  chk_carry_clear: assert property (s_take ##0 opcode == 8'h24 |=> branch_taken == !$past(ccr_in[CC_C]))
    else $error("carry clear branch decision wrong");
  chk_lower_same: assert property (s_take ##0 opcode == 8'h23 |=>
      branch_taken == ($past(ccr_in[CC_C]) || $past(ccr_in[CC_Z])))
    else $error("lower or same branch decision wrong");
  chk_half_mask: assert property (s_take ##0 opcode inside {8'h28, 8'h29, 8'h2C, 8'h2D} |=>
      branch_taken == !($past(opcode[0]) ^ ($past(opcode[2]) ? $past(ccr_in[CC_I]) : $past(ccr_in[CC_H]))))
    else $error("half carry or mask branch decision wrong");
  chk_rel_target: assert property (s_rel |=> next_pc == (branch_taken ?
      $past(instr_pc) + 16'h2 + {{8{$past(byte1[7])}}, $past(byte1)} : $past(instr_pc) + 16'h2))
    else $error("branch next address wrong");
  chk_branch_sub: assert property (s_take ##0 opcode == OPC_BRANCH_SUB |=>
      push_return && cycles_out == 4'h6 && return_addr == $past(instr_pc) + 16'h2)
    else $error("branch to subroutine wrong");
  chk_flags_kept: assert property (s_rel |=> ccr_out == $past(ccr_in))
    else $error("branch changed the flags");
endmodule  // rbd_decoder_assertions

// ---- sim/rbd_mem_model.sv ----
/*
  rbd_mem_model: data memory on the core bus, answering with an address pattern.
  Assumes the bench selects it while presenting an operand address.
*/
`timescale 1ns/1ps
module rbd_mem_model (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        sel,
  input wire logic [15:0] addr,
  output logic [7:0]      data
);
  logic [7:0] last_ff;   // value last driven while selected
  logic [7:0] nxt_last;

  // selected: address pattern; released: inverse of the last value, never a stale copy
  always_comb begin
    nxt_last = last_ff;
    if (sel) nxt_last = addr[7:0] ^ addr[15:8] ^ 8'h3C;
  end
  always_ff @(posedge clk) begin
    if (reset) last_ff <= 8'h00;
    else last_ff <= nxt_last;
  end
  assign data = sel ? nxt_last : ~last_ff;
endmodule  // rbd_mem_model

// ---- sim/rbd_decoder_tb_top.sv ----
/*
  rbd_decoder_tb_top: self-checking bench for the decoder with a data memory model.
  Assumes a 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module rbd_decoder_tb_top;
  import rbd_pkg::*;
  logic clk, reset, start, irq_pin, dsel, busy, done, irq_take, illegal;
  logic branch_taken, push_return, acc_we, idx_we, mem_we;
  logic [7:0] opcode, byte1, byte2, acc_in, idx_in, mem_data, result;
  logic [15:0] instr_pc, daddr, next_pc, eff_addr, return_addr;
  logic [4:0] ccr_in, ccr_out;
  logic [1:0] len_out;
  logic [3:0] cycles_out;
  rbd_op_type op_out;
  rbd_mode_type mode_out;
  int error_cnt = 0;
  int checked = 0;

  // device under test and the data memory on its far side
  rbd_decoder u_dut (.clk(clk), .reset(reset), .start(start), .opcode(opcode), .byte1(byte1),
    .byte2(byte2), .instr_pc(instr_pc), .mem_data(mem_data), .acc_in(acc_in), .idx_in(idx_in),
    .ccr_in(ccr_in), .irq_pin(irq_pin), .busy(busy), .done(done), .irq_take(irq_take),
    .op_out(op_out), .mode_out(mode_out), .len_out(len_out), .cycles_out(cycles_out),
    .illegal(illegal), .branch_taken(branch_taken), .next_pc(next_pc), .eff_addr(eff_addr),
    .push_return(push_return), .return_addr(return_addr), .result(result), .acc_we(acc_we),
    .idx_we(idx_we), .mem_we(mem_we), .ccr_out(ccr_out));
  rbd_mem_model u_mem (.clk(clk), .reset(reset), .sel(dsel), .addr(daddr), .data(mem_data));

  // compare helpers
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  // one instruction: present, let it be taken, count cycles until done
  task automatic issue(input logic [7:0] op, b1, b2, input logic [15:0] pc, input logic [7:0] a, x,
                       input logic [4:0] cc, input logic [15:0] da, output int cyc);
    @(posedge clk);
    start <= 1'b1;
    opcode <= op;
    byte1 <= b1;
    byte2 <= b2;
    instr_pc <= pc;
    acc_in <= a;
    idx_in <= x;
    ccr_in <= cc;
    daddr <= da;
    dsel <= (op[7:4] != NIB_IMM) && (op[7:4] != NIB_REL);
    @(posedge clk);
    start <= 1'b0;
    dsel <= 1'b0;
    #1;
    cyc = 1;
    while (done !== 1'b1 && cyc < 20) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    cyc++;
  endtask

  // masked interrupt stays pending until the mask clears
  task automatic t_irq;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      irq_pin <= (k >= 6);
      #1;
      chk_bit(irq_take, 1'b0);
    end
    @(posedge clk);
    ccr_in <= 5'h00;
    #1;
    chk_bit(irq_take, 1'b1);
    @(posedge clk);
    #1;
    chk_bit(irq_take, 1'b0);
  endtask

  // five operations across all six memory modes
  task automatic t_regmem;
    logic [3:0] ops [5] = '{LN_ADC, LN_SWB, LN_XOR, LN_CPA, LN_BIT};
    rbd_op_type opt [5] = '{OP_ADD_CARRY, OP_SUBTRACT_WITH_BORROW, OP_EXCLUSIVE_OR_ACC,
                            OP_COMPARE_ACCUMULATOR, OP_BIT_TEST};
    logic [3:0] nibs [6] = '{4'hA, 4'hB, 4'hC, 4'hF, 4'hE, 4'hD};
    rbd_mode_type modes [6] = '{MODE_IMM, MODE_DIR, MODE_EXT, MODE_IX, MODE_IX1, MODE_IX2};
    logic [1:0] lens [6] = '{2'd2, 2'd2, 2'd3, 2'd1, 2'd2, 2'd3};
    logic [15:0] eas [6] = '{16'h0000, 16'h00C5, 16'hC53A, 16'h00D4, 16'h0199, 16'hC60E};
    logic [3:0] cycs [6] = '{4'h2, 4'h3, 4'h4, 4'h3, 4'h4, 4'h5};
    logic [15:0] ea;
    logic [7:0] a, m, r;
    logic [4:0] hs;
    int n;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 6; j++) begin
        a = 8'h9C + 8'(j);
        ea = eas[j];
        m = (j == 0) ? 8'hC5 : pat(ea);
        r = (i == 0) ? a + m + 8'h01 : (i == 1) ? a - m - 8'h01 : a ^ m;
        hs = {1'b0, a[3:0]} + {1'b0, m[3:0]} + 5'h01;
        issue({nibs[j], ops[i]}, 8'hC5, 8'h3A, 16'h0300, a, 8'hD4, 5'h01, ea, n);
        chk_val({11'h0, op_out}, {11'h0, opt[i]});
        chk_val({13'h0, mode_out}, {13'h0, modes[j]});
        chk_val({14'h0, len_out}, {14'h0, lens[j]});
        chk_val(16'(n), {12'h0, cycs[j]});
        if (j > 0) chk_val(eff_addr, ea);
        chk_bit(acc_we, i < 3);
        if (i < 3) chk_val({8'h00, result}, {8'h00, r});
        if (i == 0) chk_bit(ccr_out[CC_H], hs[4]);
        if (i == 3) chk_bit(ccr_out[CC_C], a < m);
      end
    end
  endtask

  // all sixteen relative branches against flag sets and both pin levels
  task automatic t_branch;
    logic [4:0] ccs [4] = '{5'h00, 5'h1F, 5'h05, 5'h1A};
    logic [15:0] pc, tgt, t;
    logic [7:0] off;
    logic h, i, ng, z, cy, tk;
    int n;
    for (int q = 0; q < 2; q++) begin
      @(posedge clk);
      irq_pin <= q[0];
      repeat (5) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        for (int c = 0; c < 16; c++) begin
          pc = 16'h4000 + 16'(c * 37);
          off = c[0] ? 8'hF0 : 8'h12;
          {h, i, ng, z, cy} = ccs[k];
          t = {q[0], !q[0], i, !i, ng, !ng, h, !h, z, !z, cy, !cy, cy | z, !(cy | z), 2'b01};
          tk = t[c];
          tgt = pc + 16'h2 + {{8{off[7]}}, off};
          issue({4'h2, 4'(c)}, off, 8'h77, pc, 8'h55, 8'h66, ccs[k], 16'h0000, n);
          chk_bit(branch_taken, tk);
          chk_val(next_pc, tk ? tgt : pc + 16'h2);
          chk_val({10'h0, len_out, cycles_out}, {10'h0, 2'd2, 4'h3});
          chk_val(16'(n), 16'h3);
          chk_val({11'h0, ccr_out}, {11'h0, ccs[k]});
        end
      end
    end
  endtask

  // subroutine branch, both jump kinds, a direct store and the illegal immediate store
  task automatic t_jump;
    int n;
    issue(OPC_BRANCH_SUB, 8'h80, 8'h00, 16'h2000, 8'h11, 8'h22, 5'h00, 16'h0000, n);
    chk_val(16'(n), 16'h6);
    chk_val(return_addr, 16'h2002);
    chk_val(next_pc, 16'h1F82);
    chk_bit(push_return & branch_taken, 1'b1);
    issue(8'hCC, 8'h12, 8'h34, 16'h2100, 8'h11, 8'h22, 5'h00, 16'h1234, n);
    chk_val({11'h0, op_out}, {11'h0, OP_JUMP_ALWAYS});
    chk_val(16'(n), 16'h3);
    chk_val(next_pc, 16'h1234);
    chk_bit(acc_we | idx_we | mem_we | illegal, 1'b0);
    issue(8'hCD, 8'h56, 8'h78, 16'h2200, 8'h11, 8'h22, 5'h00, 16'h5678, n);
    chk_val(16'(n), 16'h6);
    chk_val(return_addr, 16'h2203);
    chk_val(next_pc, 16'h5678);
    issue(8'hB7, 8'h40, 8'h00, 16'h2300, 8'h5A, 8'h22, 5'h00, 16'h0040, n);
    chk_bit(mem_we, 1'b1);
    issue(8'hA7, 8'h40, 8'h00, 16'h2300, 8'h5A, 8'h22, 5'h00, 16'h0040, n);
    chk_bit(illegal, 1'b1);
  endtask

  // verdict and end of run
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end

  // main sequence
  initial begin
    reset = 1'b1;
    start = 1'b0;
    irq_pin = 1'b1;
    dsel = 1'b0;
    opcode = 8'h00;
    byte1 = 8'h00;
    byte2 = 8'h00;
    instr_pc = 16'h0000;
    acc_in = 8'h00;
    idx_in = 8'h00;
    ccr_in = 5'h08;
    daddr = 16'h0000;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_irq();
    t_regmem();
    t_branch();
    t_jump();
    results();
  end
endmodule  // rbd_decoder_tb_top

bind rbd_decoder rbd_decoder_assertions u_chk (.clk(clk), .reset(reset), .start(start),
  .opcode(opcode), .byte1(byte1), .instr_pc(instr_pc), .ccr_in(ccr_in), .busy(busy), .done(done),
  .op_out(op_out), .len_out(len_out), .cycles_out(cycles_out), .branch_taken(branch_taken),
  .next_pc(next_pc), .push_return(push_return), .return_addr(return_addr), .acc_we(acc_we),
  .ccr_out(ccr_out));
